//--- design/rx_cal_regs_pkg.sv
package rx_cal_regs_pkg;
    // ==========================================================
    // Register offsets
    localparam logic [7:0] EXT_RX_STATUS_ADDR = 8'h2e;
    localparam logic [7:0] FILTER_CAL_STATUS_ADDR = 8'h2f;
    localparam logic [7:0] QUAD_CAL_CONTROL_ADDR = 8'h30;
    localparam logic [1:0] CAL_BANK = 2'h1;
    // ==========================================================
    // Field positions
    localparam int GAIN_BIT = 7;
    localparam int SOURCE_BIT = 6;
    localparam int SUBCMD_MSB = 5;
    localparam int SUBCMD_LSB = 4;
    localparam int COUNT_MSB = 3;
    localparam int QUAD_ACTIVE_BIT = 7;
    localparam int RC_ACTIVE_BIT = 6;
    localparam int RC_RES_MSB = 3;
    localparam int TRIGGER_BIT = 7;
    localparam int SETTING_MSB = 6;
    // ==========================================================
    // Reset values
    localparam logic [7:0] STATUS_RESET = 8'h00;
    localparam logic [6:0] SETTING_RESET = 7'h00;
    // ==========================================================
    // Receive sub-command encoding
    typedef enum logic [1:0] {
        SUB_IDLE = 2'b00,
        SUB_WAKEUP_SEARCH = 2'b01,
        SUB_PREAMBLE_DETECT = 2'b10,
        SUB_DATA = 2'b11
    } rx_subcmd_t;
    // Calibration sequencer states
    typedef enum logic [1:0] {
        CAL_IDLE = 2'b00,
        CAL_START = 2'b01,
        CAL_RUN = 2'b10
    } cal_state_t;
endpackage

//--- design/snapshot_capture.sv
`timescale 1ns/10ps
`default_nettype none
// Capture register: loads a value on a strobe
module snapshot_capture #(
    parameter int WIDTH = 8
) (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic load_i,
    input wire logic [WIDTH-1:0] value_i,
    output logic [WIDTH-1:0] value_o
);
    // Held snapshot
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            value_o <= '0;
        end else if (load_i) begin
            value_o <= value_i;
        end
    end
endmodule // snapshot_capture
`default_nettype wire

//--- design/rx_status_and_filter_calibration_regs.sv
`timescale 1ns/10ps
`default_nettype none
module rx_status_and_filter_calibration_regs (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic [1:0] bank_sel_i,
    input wire logic [7:0] reg_addr_i,
    input wire logic reg_wr_i,
    input wire logic reg_rd_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic high_gain_i,
    input wire logic [1:0] rx_subcmd_i,
    input wire logic [3:0] transition_count_i,
    input wire logic auto_sample_i,
    input wire logic status_read_i,
    input wire logic rc_cal_busy_i,
    input wire logic [3:0] rc_cal_result_i,
    input wire logic quad_cal_done_i,
    input wire logic [6:0] quad_cal_best_i,
    output logic [7:0] reg_rdata_o,
    output logic quad_cal_start_o,
    output logic [6:0] quad_cal_setting_o
);
    import rx_cal_regs_pkg::*;

    logic bank_ok;
    logic snap_load;
    logic [7:0] snap_d;
    logic [7:0] snap_q;
    logic [7:0] cal_status;
    logic [7:0] quad_ctrl;
    logic wr_ctrl;
    logic trigger_q;
    logic quad_active_q;
    logic [6:0] setting_q;
    cal_state_t cal_state_q;

    // ==========================================================
    // Access decode
    assign bank_ok = (bank_sel_i == CAL_BANK);
    assign wr_ctrl = reg_wr_i && bank_ok &&
                     (reg_addr_i == QUAD_CAL_CONTROL_ADDR);

    // ==========================================================
    // Status snapshot; automatic capture takes priority
    assign snap_load = auto_sample_i || status_read_i;
    always_comb begin
        snap_d = STATUS_RESET;
        snap_d[GAIN_BIT] = high_gain_i;
        snap_d[SOURCE_BIT] = !auto_sample_i;
        snap_d[SUBCMD_MSB:SUBCMD_LSB] = rx_subcmd_i;
        snap_d[COUNT_MSB:0] = transition_count_i;
    end

    snapshot_capture #(.WIDTH(8)) u_snap (
        .core_clk_i(core_clk_i),
        .sys_rst_i(sys_rst_i),
        .load_i(snap_load),
        .value_i(snap_d),
        .value_o(snap_q)
    );

    // Calibration status and control read views
    always_comb begin
        cal_status = STATUS_RESET;
        cal_status[QUAD_ACTIVE_BIT] = quad_active_q;
        cal_status[RC_ACTIVE_BIT] = rc_cal_busy_i;
        cal_status[RC_RES_MSB:0] = rc_cal_result_i;
        quad_ctrl = {trigger_q, setting_q};
    end

    // ==========================================================
    // I/Q calibration sequencer
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            cal_state_q <= CAL_IDLE;
            trigger_q <= 1'b0;
            quad_active_q <= 1'b0;
            quad_cal_start_o <= 1'b0;
        end else begin
            quad_cal_start_o <= 1'b0;
            case (cal_state_q)
                CAL_IDLE: begin
                    if (wr_ctrl && reg_wdata_i[TRIGGER_BIT]) begin
                        trigger_q <= 1'b1;
                        quad_active_q <= 1'b1;
                        quad_cal_start_o <= 1'b1;
                        cal_state_q <= CAL_START;
                    end
                end
                CAL_START: begin
                    cal_state_q <= CAL_RUN;
                end
                CAL_RUN: begin
                    if (quad_cal_done_i) begin
                        trigger_q <= 1'b0;
                        quad_active_q <= 1'b0;
                        cal_state_q <= CAL_IDLE;
                    end
                end
                default: begin
                    cal_state_q <= CAL_IDLE;
                end
            endcase
        end
    end

    // Setting: software write, or calibration result on completion
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            setting_q <= SETTING_RESET;
        end else if (cal_state_q == CAL_RUN && quad_cal_done_i) begin
            setting_q <= quad_cal_best_i;
        end else if (wr_ctrl) begin
            setting_q <= reg_wdata_i[SETTING_MSB:0];
        end
    end

    // Registered setting output
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            quad_cal_setting_o <= SETTING_RESET;
        end else begin
            quad_cal_setting_o <= setting_q;
        end
    end

    // ==========================================================
    // Read data, registered; unmapped or other bank reads zero
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            reg_rdata_o <= STATUS_RESET;
        end else if (reg_rd_i) begin
            if (!bank_ok) begin
                reg_rdata_o <= STATUS_RESET;
            end else begin
                case (reg_addr_i)
                    EXT_RX_STATUS_ADDR: reg_rdata_o <= snap_q;
                    FILTER_CAL_STATUS_ADDR: reg_rdata_o <= cal_status;
                    QUAD_CAL_CONTROL_ADDR: reg_rdata_o <= quad_ctrl;
                    default: reg_rdata_o <= STATUS_RESET;
                endcase
            end
        end
    end

    // ==========================================================
    // Checks
    a_trig_active: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i) trigger_q == quad_active_q)
        else $error("trigger and active differ");
    a_start_pulse: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (wr_ctrl && reg_wdata_i[TRIGGER_BIT] && cal_state_q == CAL_IDLE)
        |=> quad_cal_start_o && quad_active_q ##1 !quad_cal_start_o)
        else $error("calibration did not start");
    // A trigger during a running calibration must not restart it
    a_trig_refused: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (wr_ctrl && cal_state_q != CAL_IDLE) |=> !quad_cal_start_o)
        else $error("trigger accepted while running");
    a_done_clear: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (cal_state_q == CAL_RUN && quad_cal_done_i)
        |=> !trigger_q && !quad_active_q)
        else $error("trigger not cleared");
    a_result_store: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (cal_state_q == CAL_RUN && quad_cal_done_i)
        |=> setting_q == $past(quad_cal_best_i))
        else $error("result not stored");
    a_setting_out: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        quad_cal_setting_o == $past(setting_q))
        else $error("setting output lags wrongly");
    a_auto_src: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        auto_sample_i |=> !snap_q[SOURCE_BIT]
        && snap_q[COUNT_MSB:0] == $past(transition_count_i))
        else $error("auto snapshot wrong");
    a_read_src: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (status_read_i && !auto_sample_i) |=> snap_q[SOURCE_BIT]
        && snap_q[GAIN_BIT] == $past(high_gain_i))
        else $error("read snapshot wrong");
    a_gain_snap: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        snap_load |=> snap_q[GAIN_BIT] == $past(high_gain_i))
        else $error("gain bit wrong");
    a_subcmd_snap: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        snap_load |=> snap_q[SUBCMD_MSB:SUBCMD_LSB] == $past(rx_subcmd_i))
        else $error("sub-command wrong");
    a_cal_read: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (reg_rd_i && bank_ok && reg_addr_i == FILTER_CAL_STATUS_ADDR)
        |=> reg_rdata_o[5:4] == 2'h0
        && reg_rdata_o[RC_ACTIVE_BIT] == $past(rc_cal_busy_i)
        && reg_rdata_o[RC_RES_MSB:0] == $past(rc_cal_result_i))
        else $error("calibration status read wrong");
    a_ctrl_read: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (reg_rd_i && bank_ok && reg_addr_i == QUAD_CAL_CONTROL_ADDR)
        |=> reg_rdata_o == {$past(trigger_q), $past(setting_q)})
        else $error("control read wrong");
    a_status_read: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (reg_rd_i && bank_ok && reg_addr_i == EXT_RX_STATUS_ADDR)
        |=> reg_rdata_o == $past(snap_q))
        else $error("status read wrong");
    a_bank_block: assert property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        (reg_rd_i && !bank_ok) |=> reg_rdata_o == STATUS_RESET)
        else $error("read outside bank");
    c_cal_cycle: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) quad_cal_start_o ##[1:50] !quad_active_q);
    c_auto_snap: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) auto_sample_i);
    c_read_snap: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i) status_read_i && !auto_sample_i);
    c_busy_trigger: cover property (@(posedge core_clk_i)
        disable iff (sys_rst_i)
        wr_ctrl && reg_wdata_i[TRIGGER_BIT] && cal_state_q == CAL_RUN);
endmodule // rx_status_and_filter_calibration_regs
`default_nettype wire

//--- sim/iq_cal_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================================
// I/Q calibration circuit: answers a start pulse after a delay
module iq_cal_model (
    input wire logic core_clk_i,
    input wire logic sys_rst_i,
    input wire logic start_i,
    input wire logic [7:0] cycles_i,
    input wire logic [6:0] result_i,
    output logic done_o,
    output var logic [6:0] best_o
);
    logic [7:0] cnt_q;
    logic run_q;
    // Count down from the start pulse, then report once
    always_ff @(posedge core_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
            done_o <= 1'b0;
        end else begin
            done_o <= 1'b0;
            if (start_i) begin
                run_q <= 1'b1;
                cnt_q <= cycles_i;
            end else if (run_q) begin
                cnt_q <= cnt_q - 8'h01;
                if (cnt_q == 8'h01) begin
                    run_q <= 1'b0;
                    done_o <= 1'b1;
                end
            end
        end
    end
    // Result only meaningful beside done, garbage otherwise
    assign best_o = done_o ? result_i : ~result_i;
endmodule // iq_cal_model
`default_nettype wire

//--- sim/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin num_errors++; \
    $display("[FAIL] %s exp %h got %h", nm, e, g); end end
// ==========================================================
// Register bank bench
module testbench;
    import rx_cal_regs_pkg::*;
    logic core_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [1:0] bank_sel_i = CAL_BANK;
    logic [7:0] reg_addr_i = 8'h00;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic [7:0] reg_wdata_i = 8'h00;
    logic high_gain_i = 1'b0;
    logic [1:0] rx_subcmd_i = 2'h0;
    logic [3:0] transition_count_i = 4'h0;
    logic auto_sample_i = 1'b0;
    logic status_read_i = 1'b0;
    logic rc_cal_busy_i = 1'b0;
    logic [3:0] rc_cal_result_i = 4'h0;
    logic quad_cal_done_i;
    logic [6:0] quad_cal_best_i;
    logic [7:0] reg_rdata_o;
    logic quad_cal_start_o;
    logic [6:0] quad_cal_setting_o;
    logic [7:0] cal_cycles = 8'h02;
    logic [6:0] cal_value = 7'h00;
    int num_errors = 0;
    int checks = 0;
    rx_status_and_filter_calibration_regs i_dut (
        .core_clk_i, .sys_rst_i, .bank_sel_i, .reg_addr_i, .reg_wr_i,
        .reg_rd_i, .reg_wdata_i, .high_gain_i, .rx_subcmd_i,
        .transition_count_i, .auto_sample_i, .status_read_i,
        .rc_cal_busy_i, .rc_cal_result_i, .quad_cal_done_i,
        .quad_cal_best_i, .reg_rdata_o, .quad_cal_start_o,
        .quad_cal_setting_o
    );
    iq_cal_model i_cal (
        .core_clk_i, .sys_rst_i, .start_i(quad_cal_start_o),
        .cycles_i(cal_cycles), .result_i(cal_value),
        .done_o(quad_cal_done_i), .best_o(quad_cal_best_i)
    );
    // Clock generation
    always #50 core_clk_i = ~core_clk_i;
    // ==========================================================
    // Access tasks
    task automatic stop_test();
        $display("checks %0d errors %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge core_clk_i);
        reg_wr_i <= 1'b0;
    endtask
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge core_clk_i);
        reg_rd_i <= 1'b0;
        #1 `CHK($sformatf("reg %h", a), e, reg_rdata_o)
    endtask
    task automatic snap(input logic au, input logic rq, input logic [1:0] s,
                        input logic [3:0] n, input logic g);
        @(posedge core_clk_i);
        high_gain_i <= g;
        rx_subcmd_i <= s;
        transition_count_i <= n;
        auto_sample_i <= au;
        status_read_i <= rq;
        @(posedge core_clk_i);
        auto_sample_i <= 1'b0;
        status_read_i <= 1'b0;
        high_gain_i <= !g;
        transition_count_i <= ~n;
    endtask
    task automatic cal(input logic [7:0] cyc, input logic [6:0] v);
        int n;
        n = 0;
        cal_cycles <= cyc;
        cal_value <= v;
        wr(QUAD_CAL_CONTROL_ADDR, 8'h95);
        #1 `CHK("start", 1'b1, quad_cal_start_o)
        rd_chk(FILTER_CAL_STATUS_ADDR, 8'hca);
        // Second trigger while running: refused, setting bits still land
        if (cyc > 8'h10) begin
            wr(QUAD_CAL_CONTROL_ADDR, 8'h90);
            #1 `CHK("restart", 1'b0, quad_cal_start_o)
        end
        while (quad_cal_done_i !== 1'b1) begin
            @(posedge core_clk_i);
            #1 n++;
            if (n > 300) begin
                num_errors++;
                stop_test();
            end
        end
        rd_chk(QUAD_CAL_CONTROL_ADDR, {1'b0, v});
        rd_chk(FILTER_CAL_STATUS_ADDR, 8'h4a);
        `CHK("setting", v, quad_cal_setting_o)
        $display("test calibration done");
    endtask
    // Watchdog against a hung run
    initial begin
        repeat (20000) @(posedge core_clk_i);
        num_errors++;
        stop_test();
    end
    // ==========================================================
    // Main sequence
    initial begin
        logic [1:0] s;
        repeat (16) @(posedge core_clk_i);
        sys_rst_i <= 1'b0;
        @(posedge core_clk_i);
        #1 `CHK("rdata", 8'h00, reg_rdata_o)
        rc_cal_result_i <= 4'ha;
        rd_chk(FILTER_CAL_STATUS_ADDR, 8'h0a);
        rc_cal_busy_i <= 1'b1;
        rd_chk(FILTER_CAL_STATUS_ADDR, 8'h4a);
        wr(FILTER_CAL_STATUS_ADDR, 8'hff);
        rd_chk(FILTER_CAL_STATUS_ADDR, 8'h4a);
        $display("test rc status done");
        for (int k = 0; k < 4; k++) begin
            s = k[1:0];
            snap(s[0], !s[0], s, {s, ~s}, s[1]);
            rd_chk(8'h2e, {s[1], ~s[0], s, s, ~s});
        end
        wr(EXT_RX_STATUS_ADDR, 8'h00);
        rd_chk(EXT_RX_STATUS_ADDR, 8'hbc);
        snap(1'b1, 1'b1, 2'h2, 4'h6, 1'b0);
        rd_chk(EXT_RX_STATUS_ADDR, 8'h26);
        $display("test snapshot done");
        bank_sel_i <= 2'h0;
        rd_chk(FILTER_CAL_STATUS_ADDR, 8'h00);
        wr(QUAD_CAL_CONTROL_ADDR, 8'h7f);
        bank_sel_i <= CAL_BANK;
        rd_chk(QUAD_CAL_CONTROL_ADDR, 8'h00);
        rd_chk(8'h31, 8'h00);
        $display("test bank done");
        cal(8'h02, 7'h5a);
        cal(8'h28, 7'h21);
        wr(QUAD_CAL_CONTROL_ADDR, 8'h2c);
        #1 `CHK("start", 1'b0, quad_cal_start_o)
        rd_chk(QUAD_CAL_CONTROL_ADDR, 8'h2c);
        `CHK("setting", 7'h2c, quad_cal_setting_o)
        $display("test setting done");
        stop_test();
    end
endmodule // testbench
`default_nettype wire
